// ---- design/mii_if.sv ----
`default_nettype none
interface mii_if;
	logic [3:0] txd;
	logic       tx_en;
	logic       tx_er;
	logic       tx_clk;
	logic       rx_clk;
	logic [3:0] rxd;
	logic       rx_dv;
	logic       rx_er;
	logic       col;
	logic       crs;

	modport phy (input txd, tx_en, tx_er, output tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs);
	modport mac (output txd, tx_en, tx_er, input tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs);
endinterface : mii_if
`default_nettype wire

// ---- design/mii_mac.sv ----
`include "mii_map.svh"
`default_nettype none

module mii_mac (
	input  wire logic              mclk,
	input  wire logic              rst_b,
	mii_if.mac                     mii,
	input  wire logic              tx_valid,
	input  wire mii_pkg::mii_nib_t tx_data,
	input  wire logic              tx_err_in,
	output logic                   tx_take,
	output mii_pkg::mii_nib_t      rx_nib,
	output logic                   rx_err,
	output logic                   rx_strobe,
	output logic                   crs,
	output logic                   col
);
	mii_pkg::mii_mac_st_t s;
	mii_pkg::mii_mac_st_t next_s;
	logic                 tx_fall;
	logic                 rx_rise;

	assign tx_fall = s.tx_prev & ~s.sy2[`MII_SYM_TXCLK];
	assign rx_rise = ~s.rx_prev & s.sy2[`MII_SYM_RXCLK];

	always_comb begin
		next_s         = s;
		next_s.sy1     = {mii.rx_clk, mii.tx_clk, mii.col, mii.crs, mii.rx_er, mii.rx_dv, mii.rxd};
		next_s.sy2     = s.sy1;
		next_s.tx_prev = s.sy2[`MII_SYM_TXCLK];
		next_s.rx_prev = s.sy2[`MII_SYM_RXCLK];
		next_s.tx_take   = 1'b0;
		next_s.rx_strobe = 1'b0;
		// Pins move on the falling edge so they are settled well before the PHY samples
		if (tx_fall) begin
			next_s.txd     = tx_valid ? tx_data : '0;
			next_s.tx_en   = tx_valid;
			next_s.tx_er   = tx_valid & tx_err_in;
			next_s.tx_take = tx_valid;
		end
		if (rx_rise) begin
			next_s.rx_nib    = s.sy2[3:0];
			next_s.rx_err    = s.sy2[`MII_SYM_ER];
			next_s.rx_strobe = s.sy2[`MII_SYM_DV] | s.sy2[`MII_SYM_ER];
		end
		next_s.crs = s.sy2[`MII_SYM_CRS];
		next_s.col = s.sy2[`MII_SYM_COL];
		if (!rst_b) begin
			next_s = '0;
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign mii.txd   = s.txd;
	assign mii.tx_en = s.tx_en;
	assign mii.tx_er = s.tx_er;
	assign tx_take   = s.tx_take;
	assign rx_nib    = s.rx_nib;
	assign rx_err    = s.rx_err;
	assign rx_strobe = s.rx_strobe;
	assign crs       = s.crs;
	assign col       = s.col;
endmodule : mii_mac
`default_nettype wire

// ---- design/mii_map.svh ----
`ifndef MII_MAP_SVH
`define MII_MAP_SVH
`define MII_MCLK_HZ      40000000
`define MII_CLK10_HZ     2500000
`define MII_CLK100_HZ    25000000
`define MII_HALF10       (`MII_MCLK_HZ / (2 * `MII_CLK10_HZ))
`define MII_HALF100      (`MII_MCLK_HZ / (2 * `MII_CLK100_HZ))
`define MII_NIB_W        4
`define MII_RXW_ERR      4
`define MII_RXW_W        5
`define MII_FIFO_DEPTH   4
`define MII_SYP_ER       5
`define MII_SYP_EN       4
`define MII_SYM_RXCLK    9
`define MII_SYM_TXCLK    8
`define MII_SYM_COL      7
`define MII_SYM_CRS      6
`define MII_SYM_ER       5
`define MII_SYM_DV       4
`endif

// ---- design/mii_phy.sv ----
// Behaviour
// - MAC changes transmit nibble only with TX_CLK
// - Nibble bit 0 is least significant
// - MAC asserts TX_EN exactly with valid data
// - PHY makes TX_CLK, 2.5 or 25 MHz; the default dividers give 2.5 or 20 MHz from the 40 MHz mclk
// - Receive nibble changes only with RX_CLK
// - RX_DV high while receive nibble valid
// - RX_ER reports receive error, RX_CLK synchronous
// - MAC signals transmit error on TX_ER
// - PHY makes RX_CLK, 25 or 2.5 MHz; the default dividers give 20 or 2.5 MHz from the 40 MHz mclk
// - COL high for whole collision, unclocked
// - COL held inactive in full duplex
// - Half duplex: CRS on transmit or receive
// - Full duplex: CRS on receive only
// - CRS rises freely, falls with RX_CLK
`include "mii_map.svh"
`default_nettype none

// Stream buffer for receive words; valid and ready on both sides
module mii_fifo #(
	parameter int unsigned W     = `MII_RXW_W,
	parameter int unsigned DEPTH = `MII_FIFO_DEPTH
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
	} mii_fifo_st_t;

	mii_fifo_st_t s;
	mii_fifo_st_t next_s;
	logic         push;
	logic         pop;

	function automatic logic [AW-1:0] mii_bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : mii_bump

	assign push      = in_valid & s.rdy;
	assign pop       = out_ready & (s.cnt != '0);
	assign in_ready  = s.rdy;
	assign out_valid = (s.cnt != '0);
	assign out_data  = s.mem[s.rp];

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp        = mii_bump(s.wp);
		end
		if (pop) begin
			next_s.rp = mii_bump(s.rp);
		end
		next_s.cnt = (AW + 1)'(s.cnt + push - pop);
		// Ready is registered so the source sees a flop, and drops only once the buffer holds DEPTH words
		next_s.rdy = (next_s.cnt != (AW + 1)'(DEPTH));
		if (!rst_b) begin
			next_s     = '0;
			next_s.rdy = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end
endmodule : mii_fifo

// PHY end: sources both link clocks, samples transmit pins, plays out receive words
module mii_phy #(
	parameter int unsigned HALF_SLOW = mii_pkg::mii_min1(`MII_HALF10),
	parameter int unsigned HALF_FAST = mii_pkg::mii_min1(`MII_HALF100)
) (
	input  wire logic            mclk,
	input  wire logic            rst_b,
	mii_if.phy                   mii,
	input  wire logic            speed_fast,
	input  wire logic            full_duplex,
	input  wire logic            line_carrier,
	input  wire logic            line_collision,
	input  wire logic            rx_in_valid,
	output logic                 rx_in_ready,
	input  wire mii_pkg::mii_nib_t rx_in_data,
	input  wire logic            rx_in_err,
	output mii_pkg::mii_nib_t    tx_nib,
	output logic                 tx_en,
	output logic                 tx_err,
	output logic                 tx_strobe
);
	mii_pkg::mii_phy_st_t s;
	mii_pkg::mii_phy_st_t next_s;
	logic                 tick;
	logic                 rise;
	logic                 fall;
	logic                 f_valid;
	logic [4:0]           f_data;
	logic                 carrier_want;
	mii_pkg::mii_cnt_t    reload;
	mii_pkg::mii_nib_t    syn_txd;
	logic                 syn_en;
	logic                 syn_er;
	logic                 rx_carrier;
	logic                 tx_carrier;
	logic                 col_want;

	// Half period minus one, because the reload cycle itself counts
	function automatic mii_pkg::mii_cnt_t mii_half_load(input int unsigned half);
		return mii_pkg::mii_cnt_t'(half - 1);
	endfunction : mii_half_load

	// Both link clocks come from one divider so RX and TX edges stay phase locked
	// Speed changes land at the next reload, so no half period is cut short
	assign reload = speed_fast ? mii_half_load(HALF_FAST) : mii_half_load(HALF_SLOW);
	assign tick   = (s.div == '0);
	assign rise   = tick & ~s.tx_clk;
	assign fall   = tick & s.tx_clk;

	// Only the second synchroniser stage is read; the first may be metastable
	assign syn_txd = s.sy2[3:0];
	assign syn_en  = s.sy2[`MII_SYP_EN];
	assign syn_er  = s.sy2[`MII_SYP_ER];

	// Receive carrier counts in both modes, own transmission only in half duplex
	assign rx_carrier   = line_carrier | s.rx_dv;
	assign tx_carrier   = ~full_duplex & s.tx_en;
	assign carrier_want = rx_carrier | tx_carrier;
	assign col_want     = line_collision & ~full_duplex;

	mii_fifo #(
		.W     (`MII_RXW_W),
		.DEPTH (`MII_FIFO_DEPTH)
	) mii_fifo_inst (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   ({rx_in_err, rx_in_data}),
		.out_valid (f_valid),
		.out_ready (fall),
		.out_data  (f_data)
	);

	always_comb begin
		next_s     = s;
		next_s.sy1 = {mii.tx_er, mii.tx_en, mii.txd};
		next_s.sy2 = s.sy1;
		next_s.tx_strobe = 1'b0;
		if (tick) begin
			next_s.div    = reload;
			next_s.tx_clk = ~s.tx_clk;
			next_s.rx_clk = ~s.rx_clk;
		end else begin
			next_s.div = mii_pkg::mii_cnt_t'(s.div - 1'b1);
		end
		// Sampled at the rising edge; the MAC moved its pins at the falling one
		if (rise) begin
			next_s.tx_nib    = syn_txd;
			next_s.tx_en     = syn_en;
			next_s.tx_err    = syn_er & syn_en;
			next_s.tx_strobe = syn_en;
		end
		// FIFO underrun mid frame drops RX_DV; the source must keep it fed
		if (fall) begin
			next_s.rxd   = f_valid ? f_data[3:0] : '0;
			next_s.rx_dv = f_valid;
			next_s.rx_er = f_valid & f_data[`MII_RXW_ERR];
		end
		if (carrier_want) begin
			next_s.crs = 1'b1;
		end else if (fall) begin
			next_s.crs = 1'b0;
		end
		// Collision is a plain flop; nothing aligns it to the link clock
		next_s.col = col_want;
		// Reset stops both link clocks low, so the first tick after release is a rise
		if (!rst_b) begin
			next_s = '0;
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign mii.tx_clk = s.tx_clk;
	assign mii.rx_clk = s.rx_clk;
	assign mii.rxd    = s.rxd;
	assign mii.rx_dv  = s.rx_dv;
	assign mii.rx_er  = s.rx_er;
	assign mii.col    = s.col;
	assign mii.crs    = s.crs;
	assign tx_nib     = s.tx_nib;
	assign tx_en      = s.tx_en;
	assign tx_err     = s.tx_err;
	assign tx_strobe  = s.tx_strobe;
endmodule : mii_phy
`default_nettype wire

// ---- design/mii_pkg.sv ----
`default_nettype none
package mii_pkg;
	typedef logic [3:0] mii_nib_t;
	typedef logic [7:0] mii_cnt_t;

	typedef struct packed {
		mii_cnt_t div;
		logic     tx_clk;
		logic     rx_clk;
		logic [5:0] sy1;
		logic [5:0] sy2;
		mii_nib_t tx_nib;
		logic     tx_en;
		logic     tx_err;
		logic     tx_strobe;
		mii_nib_t rxd;
		logic     rx_dv;
		logic     rx_er;
		logic     col;
		logic     crs;
	} mii_phy_st_t;

	typedef struct packed {
		logic [9:0] sy1;
		logic [9:0] sy2;
		logic     tx_prev;
		logic     rx_prev;
		mii_nib_t txd;
		logic     tx_en;
		logic     tx_er;
		logic     tx_take;
		mii_nib_t rx_nib;
		logic     rx_err;
		logic     rx_strobe;
		logic     crs;
		logic     col;
	} mii_mac_st_t;

	function automatic int unsigned mii_min1(input int unsigned v);
		return (v < 1) ? 1 : v;
	endfunction : mii_min1
endpackage : mii_pkg
`default_nettype wire

// ---- sim/mii_chk.sv ----
`default_nettype none
module mii_chk #(
	parameter int unsigned HALF_SLOW = 8,
	parameter int unsigned HALF_FAST = 7
) (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       full_duplex,
	input wire logic       line_collision,
	input wire logic       line_carrier,
	input wire logic       tx_clk,
	input wire logic       rx_clk,
	input wire logic [3:0] rxd,
	input wire logic       rx_dv,
	input wire logic       rx_er,
	input wire logic       col,
	input wire logic       crs
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic tx_q;
	logic seen;
	int   run;
	// Run length of the last clock level, valid once a full half has passed
	always_ff @(posedge mclk) begin
		tx_q <= tx_clk;
		if (!rst_b) begin
			seen <= 1'b0;
			run  <= 0;
		end else begin
			seen <= seen | (tx_clk != tx_q);
			run  <= (tx_clk != tx_q) ? 1 : run + 1;
		end
	end
	sequence s_rx_fall;
		$fell(rx_clk);
	endsequence
	sequence s_rx_demand;
		line_carrier || rx_dv;
	endsequence
	a_half_len: assert property (seen && tx_clk != tx_q |-> run == HALF_SLOW || run == HALF_FAST)
		else $error("link clock half period wrong");
	a_clk_same: assert property (rx_clk == tx_clk) else $error("receive clock differs");
	a_rxd_edge: assert property ($changed(rxd) |-> s_rx_fall) else $error("rxd off clock");
	a_rxdv_edge: assert property ($changed(rx_dv) |-> s_rx_fall) else $error("rx_dv off clock");
	a_rxer_edge: assert property ($changed(rx_er) |-> s_rx_fall) else $error("rx_er off clock");
	a_col_half: assert property (line_collision && !full_duplex |=> col) else $error("col missing");
	a_col_full: assert property (full_duplex |=> !col) else $error("col in full duplex");
	a_crs_rx: assert property (s_rx_demand |=> crs) else $error("crs missing on receive");
	a_crs_fall: assert property ($fell(crs) |-> s_rx_fall) else $error("crs fell off clock");
	a_crs_full: assert property ($rose(crs) && $past(full_duplex) |-> $past(line_carrier) || $past(rx_dv))
		else $error("crs on transmit in full duplex");
endmodule : mii_chk
`default_nettype wire

// ---- sim/tb_phy_mii_data_port.sv ----
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_phy_mii_data_port;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned HS = 8;
	localparam int unsigned HF = 7;
	logic mclk, rst_b, speed_fast, full_duplex, line_carrier, line_collision;
	logic rx_in_valid, rx_in_ready, rx_in_err, p_en, p_er, p_stb;
	logic tx_valid, tx_err_in, tx_take, m_er, m_stb, m_crs, m_col, w_dv, w_en;
	logic [3:0] rx_in_data, p_nib, tx_data, m_nib, w_rxd, w_txd;
	logic [4:0] rq[$];
	logic [4:0] tq[$];
	int error_cnt = 0;
	int checks = 0;
	mii_if mii_if_inst ();
	mii_phy #(.HALF_SLOW(HS), .HALF_FAST(HF)) mii_phy_inst (.mclk(mclk), .rst_b(rst_b), .mii(mii_if_inst),
		.speed_fast(speed_fast), .full_duplex(full_duplex), .line_carrier(line_carrier),
		.line_collision(line_collision), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
		.rx_in_data(rx_in_data), .rx_in_err(rx_in_err), .tx_nib(p_nib), .tx_en(p_en), .tx_err(p_er), .tx_strobe(p_stb));
	mii_mac mii_mac_inst (.mclk(mclk), .rst_b(rst_b), .mii(mii_if_inst), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_err_in(tx_err_in), .tx_take(tx_take), .rx_nib(m_nib), .rx_err(m_er), .rx_strobe(m_stb), .crs(m_crs), .col(m_col));
	mii_chk #(.HALF_SLOW(HS), .HALF_FAST(HF)) mii_chk_inst (.mclk(mclk), .rst_b(rst_b), .full_duplex(full_duplex),
		.line_collision(line_collision), .line_carrier(line_carrier), .tx_clk(mii_if_inst.tx_clk),
		.rx_clk(mii_if_inst.rx_clk), .rxd(mii_if_inst.rxd), .rx_dv(mii_if_inst.rx_dv), .rx_er(mii_if_inst.rx_er),
		.col(mii_if_inst.col), .crs(mii_if_inst.crs));
	always #12.5 mclk = ~mclk;
	// First nibble of each frame as seen on the wire, to pin down bit order
	always @(posedge mclk) begin
		w_dv <= mii_if_inst.rx_dv;
		w_en <= mii_if_inst.tx_en;
		if (mii_if_inst.rx_dv && !w_dv) w_rxd <= mii_if_inst.rxd;
		if (mii_if_inst.tx_en && !w_en) w_txd <= mii_if_inst.txd;
		if (m_stb) rq.push_back({m_er, m_nib});
		if (p_stb) tq.push_back({p_er, p_nib});
	end
	task tally_and_finish;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task lim(input int n, input int top);
		if (n >= top) begin
			error_cnt++;
			$display("[ERR] wait exp done got timeout");
			tally_and_finish;
		end
	endtask : lim
	task t_clk(input logic fast);
		int hi, lo, n;
		speed_fast <= fast;
		repeat (40) @(posedge mclk);
		for (n = 0; n < 60 && mii_if_inst.tx_clk !== 1'b0; n++) @(posedge mclk);
		lim(n, 60);
		for (n = 0; n < 60 && mii_if_inst.tx_clk !== 1'b1; n++) @(posedge mclk);
		lim(n, 60);
		for (hi = 0; hi < 20 && mii_if_inst.tx_clk === 1'b1; hi++) @(posedge mclk);
		for (lo = 0; lo < 20 && mii_if_inst.tx_clk === 1'b0; lo++) @(posedge mclk);
		`CHK("clk high", fast ? HF : HS, hi)
		`CHK("clk low", fast ? HF : HS, lo)
		$display("t_clk done");
	endtask : t_clk
	// Six words against a four-deep buffer: the link, fast or slow, must stall the producer
	task t_rx;
		int i, n, refused;
		rq.delete();
		refused = 0;
		for (i = 0, n = 0; i < 6 && n < 500; n++) begin
			rx_in_valid <= 1'b1;
			rx_in_data  <= 4'hA ^ i[3:0];
			rx_in_err   <= (i == 2);
			@(posedge mclk);
			if (rx_in_ready) i++;
			else refused++;
		end
		rx_in_valid <= 1'b0;
		lim(n, 500);
		for (n = 0; n < 2000 && rq.size() < 6; n++) @(posedge mclk);
		lim(n, 2000);
		repeat (40) @(posedge mclk);
		`CHK("rx refused", 1, refused > 0)
		`CHK("rx count", 6, rq.size())
		for (i = 0; i < 6; i++) `CHK("rx word", {i == 2, 4'hA ^ i[3:0]}, rq[i])
		`CHK("wire rxd first", 4'hA, w_rxd)
		`CHK("rx_dv idle", 1'b0, mii_if_inst.rx_dv)
		$display("t_rx done");
	endtask : t_rx
	task t_tx(input logic fd);
		int i, n;
		logic hi, en;
		full_duplex <= fd;
		tq.delete();
		hi = 1'b0;
		en = 1'b0;
		repeat (64) @(posedge mclk);
		for (i = 0, n = 0; i < 3 && n < 500; n++) begin
			tx_valid  <= 1'b1;
			tx_data   <= 4'h3 << i;
			tx_err_in <= (i == 1);
			@(posedge mclk);
			hi |= (m_crs === 1'b1);
			en |= (p_en === 1'b1);
			if (tx_take) i++;
		end
		tx_valid <= 1'b0;
		lim(n, 500);
		for (n = 0; n < 100; n++) begin
			@(posedge mclk);
			hi |= (m_crs === 1'b1);
			en |= (p_en === 1'b1);
		end
		`CHK("tx count", 3, tq.size())
		`CHK("tx_en seen", 1'b1, en)
		`CHK("tx_en idle", 1'b0, p_en)
		for (i = 0; i < 3; i++) `CHK("tx word", {i == 1, 4'h3 << i}, tq[i])
		`CHK("wire txd first", 4'h3, w_txd)
		`CHK("crs on tx", !fd, hi)
		$display("t_tx done");
	endtask : t_tx
	// Second reset in mid-run: everything idle again, buffer ready
	task t_reset;
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		`CHK("reset ready", 1'b1, rx_in_ready)
		`CHK("reset rx_dv", 1'b0, mii_if_inst.rx_dv)
		`CHK("reset clk", 1'b0, mii_if_inst.tx_clk)
		rst_b <= 1'b1;
		$display("t_reset done");
	endtask : t_reset
	task t_line;
		full_duplex    <= 1'b0;
		line_collision <= 1'b1;
		line_carrier   <= 1'b1;
		repeat (8) @(posedge mclk);
		`CHK("col half", 1'b1, m_col)
		`CHK("crs carrier", 1'b1, m_crs)
		full_duplex <= 1'b1;
		repeat (8) @(posedge mclk);
		`CHK("col full", 1'b0, m_col)
		`CHK("crs full rx", 1'b1, m_crs)
		line_collision <= 1'b0;
		line_carrier   <= 1'b0;
		repeat (40) @(posedge mclk);
		`CHK("crs dropped", 1'b0, m_crs)
		$display("t_line done");
	endtask : t_line
	initial begin
		{mclk, rst_b, speed_fast, full_duplex, line_carrier, line_collision} = '0;
		{rx_in_valid, rx_in_err, rx_in_data, tx_valid, tx_err_in, tx_data} = '0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		t_clk(1'b1);
		t_rx;
		t_tx(1'b0);
		t_clk(1'b0);
		t_tx(1'b1);
		t_rx;
		t_reset;
		t_line;
		tally_and_finish;
	end
endmodule : tb_phy_mii_data_port
`default_nettype wire
